// >>> design/atic_cfg.svh
// Purpose: Constants for the converter trigger and input control block.
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit registers and 10-bit result in low bits.
// Notes: Offsets other than the input disable register are local choices.
//
// Summary of operation
// - Polarity reversal bit swaps positive and negative inputs of the differential pair.
// - Control B bits 4 and 3 always read zero.
// - Trigger source field acts only while auto-trigger enable is set.
// - Auto-trigger starts a conversion on a rising edge of selected flag; edges before the last cycle of a running conversion are ignored.
// - Switching from a clear source to a set source counts as rising edge.
// - Switching to free-running code zero never makes a trigger event.
// - Codes 0..6 select free run, comparator, int0, match A, overflow, match B, pin change.
// - Input disable bits 5..2 map channels 0,2,3,1; bits 1,0 comparator inputs.
// - A disabled pin reads zero in the port input register.
// - Channel code 1111 routes and enables the temperature sensor.
// - With auto-trigger enabled, start on positive edge of selected trigger.
// - Conversion done flag sets when a conversion finishes and result updates.
// - Enable powers the converter; clearing it aborts a running conversion.
// - Bipolar mode gives two's complement 9 bits plus sign; unipolar 10 bits.
`ifndef ATIC_CFG_SVH
`define ATIC_CFG_SVH

`define ATIC_ADDR_W 8
`define ATIC_OFF_CTRL_A 8'h00
`define ATIC_OFF_CTRL_B 8'h04
`define ATIC_OFF_MUX 8'h08
`define ATIC_OFF_RESULT 8'h0C
`define ATIC_OFF_INPUT_DISABLE 8'h14
`define ATIC_OFF_PORT_IN 8'h18
`define ATIC_OFF_IRQ_STATUS 8'h1C
`define ATIC_OFF_IRQ_ENABLE 8'h20
`define ATIC_OFF_IRQ_CLEAR 8'h24

`define ATIC_A_ENABLE 7
`define ATIC_A_START 6
`define ATIC_A_AUTO 5
`define ATIC_A_DONE 4
`define ATIC_B_BIPOLAR 7
`define ATIC_B_POLREV 5
`define ATIC_B_RSV_MASK 8'hE7
`define ATIC_DIS_MASK 8'h3F
`define ATIC_MUX_CHAN_MASK 8'h0F
`define ATIC_TEMP_CODE 4'hF

`define ATIC_CONV_CYCLES 13
`define ATIC_FIRST_CONV_CYCLES 25
`define ATIC_CNT_W 5
`define ATIC_RESET_BYTE 8'h00
`define ATIC_RESP_OKAY 2'h0
`define ATIC_RESP_SLVERR 2'h2

`endif

// >>> design/atic_pkg.sv
// Purpose: Types for the converter trigger and input control block.
// Assumes: Constants live in atic_cfg.svh.
// Notes: Trigger codes follow the source field encoding.
package atic_pkg;
  typedef enum logic [2:0] {
    ATIC_TRG_FREE = 3'h0,
    ATIC_TRG_COMP = 3'h1,
    ATIC_TRG_INT0 = 3'h2,
    ATIC_TRG_MATCH_A = 3'h3,
    ATIC_TRG_OVF = 3'h4,
    ATIC_TRG_MATCH_B = 3'h5,
    ATIC_TRG_PINCHG = 3'h6,
    ATIC_TRG_RSV = 3'h7
  } atic_trg_e;

  typedef enum logic [1:0] {
    ATIC_ST_IDLE = 2'b01,
    ATIC_ST_CONV = 2'b10
  } atic_state_e;

  typedef struct packed {
    logic comparator;
    logic ext_int0;
    logic match_a;
    logic overflow;
    logic match_b;
    logic pin_change;
  } atic_trig_s;

  typedef struct packed {
    logic [3:0] pos_chan;
    logic [3:0] neg_chan;
    logic temp_sensor_en;
    logic bipolar;
    logic powered;
  } atic_route_s;
endpackage

// >>> design/atic_top.sv
// Purpose: Converter control: triggers, input disable, channel routing, registers.
// Assumes: AXI4-Lite slave, one clock, trigger flags synchronous to aclk.
// Notes: The analog core is modelled only by fixed conversion lengths, 25 cycles first and 13 after.
`timescale 1ns/100ps
`default_nettype none
`include "atic_cfg.svh"
module atic_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`ATIC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ATIC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire atic_pkg::atic_trig_s trig_flags,
  input wire logic [5:0] pin_level,
  input wire logic [9:0] analog_sample,
  output var atic_pkg::atic_route_s route_ff,
  output logic [5:0] input_buf_off_ff,
  output logic irq_ff
);
  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0] ctrl_a_ff;
  logic [7:0] ctrl_b_ff;
  logic [7:0] mux_ff;
  logic [7:0] dis_ff;
  logic [9:0] result_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_en_ff;
  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;
  logic [5:0] pin_in_ff;
  logic [`ATIC_CNT_W-1:0] cnt_ff;
  logic first_ff;
  atic_pkg::atic_state_e state_ff;

  logic aw_held_ff;
  logic w_held_ff;
  logic [`ATIC_ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;

  logic wr_fire;
  logic [`ATIC_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_lane0;
  logic trig_pulse;
  logic conv_done;
  logic conv_start;
  logic sw_start;
  logic enable_now;
  logic [7:0] nxt_rd;

  function automatic logic hit(input logic [`ATIC_ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [9:0] code_result(input logic [9:0] s, input logic bip);
    // Bipolar keeps the sign in bit 9; unipolar is full 10-bit magnitude
    code_result = bip ? {s[9], s[8:0]} : s;
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
  assign wr_fire = (aw_held_ff || s_axi_awvalid) && (w_held_ff || s_axi_wvalid) && !s_axi_bvalid;
  assign wr_lane0 = wr_fire && (w_held_ff ? wstrb_ff[0] : s_axi_wstrb[0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_awready <= !aw_held_ff;
        s_axi_wready <= !w_held_ff;
      end else begin
        if (s_axi_awvalid && !aw_held_ff && !s_axi_awready) begin
          aw_held_ff <= 1'b1;
          awaddr_ff <= s_axi_awaddr;
          s_axi_awready <= 1'b1;
        end
        if (s_axi_wvalid && !w_held_ff && !s_axi_wready) begin
          w_held_ff <= 1'b1;
          wdata_ff <= s_axi_wdata;
          wstrb_ff <= s_axi_wstrb;
          s_axi_wready <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ATIC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (hit(wr_addr, `ATIC_OFF_CTRL_A) || hit(wr_addr, `ATIC_OFF_CTRL_B) ||
                      hit(wr_addr, `ATIC_OFF_MUX) || hit(wr_addr, `ATIC_OFF_INPUT_DISABLE) ||
                      hit(wr_addr, `ATIC_OFF_IRQ_ENABLE) || hit(wr_addr, `ATIC_OFF_IRQ_CLEAR) ||
                      hit(wr_addr, `ATIC_OFF_RESULT) || hit(wr_addr, `ATIC_OFF_PORT_IN) ||
                      hit(wr_addr, `ATIC_OFF_IRQ_STATUS)) ? `ATIC_RESP_OKAY : `ATIC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  assign sw_start = wr_lane0 && hit(wr_addr, `ATIC_OFF_CTRL_A) && wr_data[`ATIC_A_START];
  assign enable_now = wr_lane0 && hit(wr_addr, `ATIC_OFF_CTRL_A) ? wr_data[`ATIC_A_ENABLE]
                                                                 : ctrl_a_ff[`ATIC_A_ENABLE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_ff <= `ATIC_RESET_BYTE;
    end else begin
      if (wr_lane0 && hit(wr_addr, `ATIC_OFF_CTRL_A)) begin
        ctrl_a_ff[`ATIC_A_ENABLE] <= wr_data[`ATIC_A_ENABLE];
        ctrl_a_ff[`ATIC_A_AUTO] <= wr_data[`ATIC_A_AUTO];
        ctrl_a_ff[3:0] <= wr_data[3:0];
      end
      // Done flag: set wins over a write-one clear in the same cycle
      if (conv_done) begin
        ctrl_a_ff[`ATIC_A_DONE] <= 1'b1;
      end else if (wr_lane0 && hit(wr_addr, `ATIC_OFF_CTRL_A) && wr_data[`ATIC_A_DONE]) begin
        ctrl_a_ff[`ATIC_A_DONE] <= 1'b0;
      end
      ctrl_a_ff[`ATIC_A_START] <= (state_ff == atic_pkg::ATIC_ST_CONV) && !conv_done &&
                                  enable_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_b_ff <= `ATIC_RESET_BYTE;
      mux_ff <= `ATIC_RESET_BYTE;
      dis_ff <= `ATIC_RESET_BYTE;
    end else if (wr_lane0) begin
      if (hit(wr_addr, `ATIC_OFF_CTRL_B)) begin
        ctrl_b_ff <= wr_data[7:0] & `ATIC_B_RSV_MASK;
      end
      if (hit(wr_addr, `ATIC_OFF_MUX)) begin
        mux_ff <= wr_data[7:0] & `ATIC_MUX_CHAN_MASK;
      end
      if (hit(wr_addr, `ATIC_OFF_INPUT_DISABLE)) begin
        dis_ff <= wr_data[7:0] & `ATIC_DIS_MASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // Trigger selection and conversion sequencing
  // ---------------------------------------------------------------
  atic_trig_sel u_trig_sel (
    .aclk(aclk),
    .aresetn(aresetn),
    .auto_en(ctrl_a_ff[`ATIC_A_AUTO]),
    .src(atic_pkg::atic_trg_e'(ctrl_b_ff[2:0])),
    .flags(trig_flags),
    .trig_pulse(trig_pulse)
  );

  // Enable as written this cycle, so start and enable may arrive in one write
  assign conv_done = (state_ff == atic_pkg::ATIC_ST_CONV) && (cnt_ff == '0) &&
                     enable_now;
  // Free running restarts right on completion, without waiting for the flag
  assign conv_start = enable_now &&
                      (sw_start || trig_pulse ||
                       (conv_done && ctrl_a_ff[`ATIC_A_AUTO] &&
                        ctrl_b_ff[2:0] == 3'h0));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= atic_pkg::ATIC_ST_IDLE;
      cnt_ff <= '0;
      first_ff <= 1'b1;
    end else if (!enable_now) begin
      state_ff <= atic_pkg::ATIC_ST_IDLE;
      cnt_ff <= '0;
      first_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        atic_pkg::ATIC_ST_IDLE: begin
          if (conv_start) begin
            state_ff <= atic_pkg::ATIC_ST_CONV;
            cnt_ff <= first_ff ? `ATIC_CNT_W'(`ATIC_FIRST_CONV_CYCLES - 1)
                               : `ATIC_CNT_W'(`ATIC_CONV_CYCLES - 1);
            first_ff <= 1'b0;
          end
        end
        atic_pkg::ATIC_ST_CONV: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - `ATIC_CNT_W'(1);
          end else if (conv_start) begin
            cnt_ff <= `ATIC_CNT_W'(`ATIC_CONV_CYCLES - 1);
          end else begin
            state_ff <= atic_pkg::ATIC_ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ff <= 10'h000;
    end else if (conv_done) begin
      result_ff <= code_result(analog_sample, ctrl_b_ff[`ATIC_B_BIPOLAR]);
    end
  end

  // ---------------------------------------------------------------
  // Analog routing and input buffers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_ff <= '0;
      input_buf_off_ff <= 6'h00;
    end else begin
      // Swapped pair lets a unipolar 10-bit conversion use either polarity
      route_ff.pos_chan <= ctrl_b_ff[`ATIC_B_POLREV] ? {2'h0, mux_ff[1:0]} : mux_ff[3:0];
      route_ff.neg_chan <= ctrl_b_ff[`ATIC_B_POLREV] ? mux_ff[3:0] : {2'h0, mux_ff[1:0]};
      route_ff.temp_sensor_en <= (mux_ff[3:0] == `ATIC_TEMP_CODE);
      route_ff.bipolar <= ctrl_b_ff[`ATIC_B_BIPOLAR];
      route_ff.powered <= ctrl_a_ff[`ATIC_A_ENABLE];
      // Bit order: ch0, ch2, ch3, ch1, comparator neg, comparator pos
      input_buf_off_ff <= dis_ff[5:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= 6'h00;
      pin_sync_ff <= 6'h00;
      pin_in_ff <= 6'h00;
    end else begin
      pin_meta_ff <= pin_level;
      pin_sync_ff <= pin_meta_ff;
      pin_in_ff <= pin_sync_ff & ~dis_ff[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts: bit0 conversion done, bit1 auto trigger edge seen while enabled
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= 2'h0;
      irq_en_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_lane0 && hit(wr_addr, `ATIC_OFF_IRQ_ENABLE)) begin
        irq_en_ff <= wr_data[1:0];
      end
      irq_stat_ff <= (irq_stat_ff & ~((wr_lane0 && hit(wr_addr, `ATIC_OFF_IRQ_CLEAR))
                                      ? wr_data[1:0] : 2'h0))
                     | {trig_pulse && enable_now, conv_done};
      irq_ff <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rd = 8'h00;
    if (hit(s_axi_araddr, `ATIC_OFF_CTRL_A)) nxt_rd = ctrl_a_ff;
    if (hit(s_axi_araddr, `ATIC_OFF_CTRL_B)) nxt_rd = ctrl_b_ff & `ATIC_B_RSV_MASK;
    if (hit(s_axi_araddr, `ATIC_OFF_MUX)) nxt_rd = mux_ff;
    if (hit(s_axi_araddr, `ATIC_OFF_INPUT_DISABLE)) nxt_rd = dis_ff;
    if (hit(s_axi_araddr, `ATIC_OFF_PORT_IN)) nxt_rd = {2'h0, pin_in_ff};
    if (hit(s_axi_araddr, `ATIC_OFF_IRQ_STATUS)) nxt_rd = {6'h00, irq_stat_ff};
    if (hit(s_axi_araddr, `ATIC_OFF_IRQ_ENABLE)) nxt_rd = {6'h00, irq_en_ff};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ATIC_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= hit(s_axi_araddr, `ATIC_OFF_RESULT) ? {22'h000000, result_ff}
                                                          : {24'h000000, nxt_rd};
        s_axi_rresp <= (hit(s_axi_araddr, `ATIC_OFF_CTRL_A) ||
                        hit(s_axi_araddr, `ATIC_OFF_CTRL_B) ||
                        hit(s_axi_araddr, `ATIC_OFF_MUX) ||
                        hit(s_axi_araddr, `ATIC_OFF_RESULT) ||
                        hit(s_axi_araddr, `ATIC_OFF_INPUT_DISABLE) ||
                        hit(s_axi_araddr, `ATIC_OFF_PORT_IN) ||
                        hit(s_axi_araddr, `ATIC_OFF_IRQ_STATUS) ||
                        hit(s_axi_araddr, `ATIC_OFF_IRQ_ENABLE) ||
                        hit(s_axi_araddr, `ATIC_OFF_IRQ_CLEAR)) ? `ATIC_RESP_OKAY
                                                                : `ATIC_RESP_SLVERR;
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/atic_trig_sel.sv
// Purpose: Picks the selected trigger flag and detects its rising edge.
// Assumes: Flags are synchronous to aclk.
// Notes: Edge is taken on the muxed signal so source switches count.
`timescale 1ns/100ps
`default_nettype none
module atic_trig_sel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic auto_en,
  input wire atic_pkg::atic_trg_e src,
  input wire atic_pkg::atic_trig_s flags,
  output logic trig_pulse
);
  logic sel_level;
  logic sel_level_ff;

  always_comb begin
    unique case (src)
      atic_pkg::ATIC_TRG_COMP: sel_level = flags.comparator;
      atic_pkg::ATIC_TRG_INT0: sel_level = flags.ext_int0;
      atic_pkg::ATIC_TRG_MATCH_A: sel_level = flags.match_a;
      atic_pkg::ATIC_TRG_OVF: sel_level = flags.overflow;
      atic_pkg::ATIC_TRG_MATCH_B: sel_level = flags.match_b;
      atic_pkg::ATIC_TRG_PINCHG: sel_level = flags.pin_change;
      atic_pkg::ATIC_TRG_FREE: sel_level = 1'b0;
      atic_pkg::ATIC_TRG_RSV: sel_level = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_level_ff <= 1'b0;
    end else begin
      sel_level_ff <= sel_level;
    end
  end

  // Mux before edge detect: clear-to-set source switch is an edge
  assign trig_pulse = auto_en && sel_level && !sel_level_ff;
endmodule
`default_nettype wire

// >>> test/atic_src_model.sv
// Purpose: Model of the on-chip event sources feeding the trigger flags.
// Assumes: Flags are levels synchronous to aclk.
// Notes: The bench asks for a flag pattern; it appears after one edge.
`timescale 1ns/100ps
`default_nettype none
module atic_src_model (
  input wire logic aclk,
  input wire logic [5:0] want,
  output var atic_pkg::atic_trig_s flags
);
  // Registered so a flag never moves in the edge that samples it
  always @(posedge aclk) begin
    flags <= want;
  end
endmodule
`default_nettype wire

// >>> test/atic_top_assertions.sv
// Purpose: Port checks for the converter control block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bus timing as the hand-over contract gives it.
`timescale 1ns/100ps
`default_nettype none
module atic_top_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] input_buf_off_ff,
  input wire logic irq_ff
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awready && s_axi_wready;
  endsequence
  sequence rd_ask;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  a_write_answered: assert property (wr_take |-> ##[0:1] s_axi_bvalid)
    else $error("write response missing");
  a_read_answered: assert property (rd_ask |-> ##[1:3] s_axi_rvalid)
    else $error("read response missing");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than a cycle");
  a_read_overlap: assert property ($past(s_axi_rvalid) && s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while one pending");
  a_resp_legal: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2)
    else $error("illegal read response");
  a_reset_quiet: assert property ($rose(aresetn) |-> !irq_ff && input_buf_off_ff == 6'h0)
    else $error("outputs not cleared by reset");
  a_bufoff_write: assert property (!$past(s_axi_wvalid) |-> $stable(input_buf_off_ff))
    else $error("input disable moved without write");
endmodule
bind atic_top atic_top_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .input_buf_off_ff(input_buf_off_ff), .irq_ff(irq_ff));
`default_nettype wire

// >>> test/atic_top_test.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: AXI4-Lite master tasks, model of event sources.
// Notes: Expected values come from the small register model below.
`timescale 1ns/100ps
`default_nettype none
module atic_top_test;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF, lo;
  logic [1:0] bresp, rresp, r;
  logic [5:0] want = 6'h0, pin = 6'h0, bufoff;
  logic [9:0] samp = 10'h0;
  atic_pkg::atic_trig_s flags;
  atic_pkg::atic_route_s route;
  int seed = 32'hEBFE;
  int error_cnt = 0, check_count = 0;
  int m_b, m_dis, m_mux, i;
  always #50 aclk = ~aclk;
  atic_src_model u_src (.aclk(aclk), .want(want), .flags(flags));
  atic_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trig_flags(flags), .pin_level(pin), .analog_sample(samp), .route_ff(route),
    .input_buf_off_ff(bufoff), .irq_ff(irq));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask
  task automatic chk_port(input logic [10:0] got, input logic [10:0] exp);
    cmp({21'h0, got}, {21'h0, exp});
  endtask
  // Signals are taken as they stood at the rising edge; late ready makes the slave hold
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    b_ok = 1'h0;
    while (!b_ok) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      b_ok = bvalid && bready;
      bready <= bvalid && !bready;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic r_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    r_ok = 1'h0;
    while (!r_ok) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      r_ok = rvalid && rready;
      v = rdata;
      rs = rresp;
      rready <= rvalid && !rready;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] rs;
    axi_rd(a, v, rs);
    chk_word(v, exp);
  endtask
  task automatic conv_case(input logic [2:0] src, input logic [7:0] ca, input logic [5:0] flg,
      input logic [1:0] st);
    want <= 6'h0;
    samp <= 10'($random(seed));
    axi_wr(8'h04, {29'h0, src});
    axi_wr(8'h00, {24'h0, ca});
    axi_wr(8'h24, 32'h3);
    want <= flg;
    repeat (40) @(posedge aclk);
    rd_chk(8'h1C, {30'h0, st});
    chk_port(irq, st != 2'h0);
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    // ----------------------------------------
    // Reset values and a refused address
    // ----------------------------------------
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h1C, 32'h0);
    axi_rd(8'h30, d, r);
    chk_word({r, d[29:0]}, 32'h80000000);
    $display("test reset done");
    // ----------------------------------------
    // Registers, input disable and routing
    // ----------------------------------------
    for (i = 0; i < 6; i++) begin
      m_b = $random(seed);
      axi_wr(8'h04, m_b);
      rd_chk(8'h04, m_b & 32'hE7);
      m_dis = $random(seed) & 32'h3F;
      pin <= 6'($random(seed));
      axi_wr(8'h14, m_dis);
      repeat (3) @(posedge aclk);
      rd_chk(8'h18, pin & ~m_dis[5:0]);
      chk_port(bufoff, m_dis[5:0]);
      m_mux = (i == 0) ? 15 : $random(seed) & 32'hF;
      lo = m_mux & 3;
      axi_wr(8'h08, m_mux);
      repeat (2) @(posedge aclk);
      chk_port(route.temp_sensor_en, m_mux == 15);
      chk_port(route, {m_b[5] ? lo : m_mux[3:0], m_b[5] ? m_mux[3:0] : lo, m_mux == 15,
        m_b[7], 1'h0});
    end
    $display("test registers done");
    // ----------------------------------------
    // Trigger sources
    // ----------------------------------------
    axi_wr(8'h20, 32'h3);
    for (i = 1; i < 7; i++) begin
      conv_case(3'(i), 8'hA0, 6'h1 << (6 - i), 2'h3);
      rd_chk(8'h0C, {22'h0, samp});
      chk_port(route.powered, 1'h1);
    end
    conv_case(3'h1, 8'h80, 6'h20, 2'h0);
    conv_case(3'h7, 8'hA0, 6'h3F, 2'h0);
    conv_case(3'h1, 8'hA0, 6'h04, 2'h0);
    axi_wr(8'h04, 32'h4);
    repeat (40) @(posedge aclk);
    rd_chk(8'h1C, 32'h3);
    rd_chk(8'h00, 32'hB0);
    // Done flag still set here, so a switch to free running is the awkward case
    axi_wr(8'h24, 32'h3);
    axi_wr(8'h04, 32'h0);
    repeat (40) @(posedge aclk);
    rd_chk(8'h1C, 32'h0);
    $display("test triggers done");
    // ----------------------------------------
    // Abort and free running
    // ----------------------------------------
    conv_case(3'h1, 8'hA0, 6'h00, 2'h0);
    // Trigger starts a conversion, then enable drops well before it can finish
    want <= 6'h20;
    repeat (3) @(posedge aclk);
    axi_wr(8'h00, 32'h20);
    repeat (40) @(posedge aclk);
    rd_chk(8'h1C, 32'h2);
    axi_wr(8'h04, 32'h0);
    axi_wr(8'h00, 32'hE0);
    repeat (40) @(posedge aclk);
    axi_wr(8'h24, 32'h3);
    repeat (20) @(posedge aclk);
    axi_rd(8'h1C, d, r);
    chk_word(d & 32'h1, 32'h1);
    axi_wr(8'h00, 32'h0);
    // Sensor reading: reference choice is outside this block, software keeps it
    samp <= 10'($random(seed));
    axi_wr(8'h08, 32'hF);
    axi_wr(8'h24, 32'h3);
    axi_wr(8'h00, 32'hC0);
    repeat (40) @(posedge aclk);
    rd_chk(8'h1C, 32'h1);
    rd_chk(8'h0C, {22'h0, samp});
    $display("test abort done");
    // ----------------------------------------
    // Interrupt mask and clear
    // ----------------------------------------
    axi_wr(8'h20, 32'h0);
    repeat (2) @(posedge aclk);
    chk_port(irq, 1'h0);
    axi_wr(8'h20, 32'h1);
    repeat (2) @(posedge aclk);
    chk_port(irq, 1'h1);
    axi_wr(8'h24, 32'h3);
    repeat (2) @(posedge aclk);
    chk_port(irq, 1'h0);
    $display("test irq done");
    close_out();
  end
endmodule
`default_nettype wire
